// file: cmp_skip_pkg.sv
// Package for the compare-and-skip execution block.
// Assumes a core with a four quarter-cycle instruction clock around it.
package cmp_skip_pkg;

  // Opcode fields and address limits of the compare-skip words.
  localparam logic [3:0]  OPC_HIGH          = 4'h6;
  localparam logic [2:0]  OPC_SUB_GREATER   = 3'h2;
  localparam logic [2:0]  OPC_SUB_LESS      = 3'h0;
  localparam int          ACCESS_BIT_POS    = 8;
  localparam logic [7:0]  INDEXED_LIMIT     = 8'h5F;
  localparam logic [3:0]  ACCESS_BANK_HIGH  = 4'hF;
  localparam logic [7:0]  ACCESS_SPLIT      = 8'h60;

  // Cycle counts of the instruction.
  localparam logic [1:0]  CYC_NO_SKIP       = 2'h1;
  localparam logic [1:0]  CYC_SKIP          = 2'h2;
  localparam logic [1:0]  CYC_SKIP_TWO_WORD = 2'h3;

  // Reset values.
  localparam logic [11:0] ADDR_RESET        = 12'h000;

  // Request from the fetch stage.
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic        next_two_word;
  } fetch_type;

  // Data memory address with the indexed flag.
  typedef struct packed {
    logic        indexed;
    logic [11:0] addr;
  } daddr_type;

  // Execution states.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_NOP1  = 4'b0100,
    ST_NOP2  = 4'b1000
  } state_type;

endpackage

// file: compare_skip_execute.sv
// Executes the compare-skip-greater and compare-skip-less instructions.
// The block decodes the fetched word, reads one data byte, compares it
// with the working register and tells fetch whether to skip.
// Assumes data memory answers a read address within the same cycle and
// that fetch flushes its held word when told to skip.
// Assumes every input is driven from logic on the same instruction clock,
// so no input passes a synchroniser.
// Summary of operation
// - Greater: unsigned byte minus working register; skip when byte is larger.
// - Less: unsigned compare; skip when byte is smaller than working register.
// - Greater decodes as 0110 010a followed by the eight-bit register field.
// - Less decodes as 0110 000a followed by the eight-bit register field.
// - A taken skip discards the fetched word and runs a no-operation.
// - One cycle without skip, two with skip, three past two-word instructions.
// - Access bit zero addresses the fixed access bank.
// - Access bit one joins bank select register with the register field.
// - Access bit zero with extended set uses indexed offset when field <= 95.
// - Any register field 0 to 255 and either access bit is accepted.
`timescale 1ns/1ns
`default_nettype none
module compare_skip_execute (
  input  wire logic                     mclk_in,         // Instruction clock.
  input  wire logic                     reset_n_in,      // Async reset, low.
  input  wire cmp_skip_pkg::fetch_type  fetch_in,        // Fetched word.
  input  wire logic [3:0]               bank_select_register_in, // Bank.
  input  wire logic                     extended_set_in, // Extended set on.
  input  wire logic [11:0]              fsr_index_in,    // Indexed base.
  input  wire logic [7:0]               working_register_in, // W value.
  input  wire logic [7:0]               data_byte_in,    // Read data byte.
  output var  cmp_skip_pkg::daddr_type  daddr_out,       // Data address.
  output var  logic                     dread_out,       // Data read strobe.
  output var  logic                     flush_out,       // Discard fetched.
  output var  logic                     busy_out,        // Stall fetch.
  output var  logic                     skip_out,        // Skip taken pulse.
  output var  logic [1:0]               cycles_out       // Cycles used.
);
  import cmp_skip_pkg::*;

  // Sequence state: where the block stands within one instruction.
  state_type   state_q;
  state_type   state_d;
  logic        greater_q;
  logic        greater_d;
  logic        two_word_q;
  logic        two_word_d;

  // Data request towards data memory.
  daddr_type   daddr_q;
  daddr_type   daddr_d;
  logic        dread_q;
  logic        dread_d;

  // Results handed to fetch and to the program counter logic.
  logic        flush_q;
  logic        flush_d;
  logic        busy_q;
  logic        busy_d;
  logic        skip_q;
  logic        skip_d;
  logic [1:0]  cycles_q;
  logic [1:0]  cycles_d;

  // Decode, address and compare results, all combinational.
  logic        is_greater;
  logic        is_less;
  logic        start;
  logic        access_bit;
  logic [7:0]  reg_field;
  logic        take;
  logic [8:0]  diff;
  daddr_type   addr_calc;

  // Decode the fetched word; every field value and access bit is legal.
  // A word is only taken while the block is idle, so a word that arrives
  // during a running sequence is simply ignored.
  always_comb begin
    reg_field  = fetch_in.word[7:0];
    access_bit = fetch_in.word[ACCESS_BIT_POS];
    is_greater = fetch_in.valid && fetch_in.word[15:12] == OPC_HIGH &&
                 fetch_in.word[11:9] == OPC_SUB_GREATER;
    is_less    = fetch_in.valid && fetch_in.word[15:12] == OPC_HIGH &&
                 fetch_in.word[11:9] == OPC_SUB_LESS;
    start      = (state_q == ST_IDLE) && (is_greater || is_less);
  end

  // Form the data address from the access bit and bank select.
  always_comb begin
    addr_calc.indexed = 1'b0;
    addr_calc.addr    = ADDR_RESET;
    if (access_bit) begin
      addr_calc.addr = {bank_select_register_in, reg_field};
    end else if (extended_set_in && reg_field <= INDEXED_LIMIT) begin
      addr_calc.indexed = 1'b1;
      addr_calc.addr    = fsr_index_in + {4'h0, reg_field};
    end else if (reg_field < ACCESS_SPLIT) begin
      addr_calc.addr = {4'h0, reg_field};
    end else begin
      addr_calc.addr = {ACCESS_BANK_HIGH, reg_field};
    end
  end

  // Unsigned compare only; nothing is written back anywhere.
  // The ninth bit of the difference is the borrow: set when the byte is
  // smaller than the working register. Equal values never skip.
  always_comb begin
    diff = {1'b0, data_byte_in} - {1'b0, working_register_in};
    if (greater_q) begin
      take = !diff[8] && diff[7:0] != 8'h00;
    end else begin
      take = diff[8];
    end
  end

  // Next sequence state. Idle takes a word, read compares the byte, and
  // one or two no-operation states follow when the skip is taken.
  // The kind of compare and the two-word flag are kept for the sequence,
  // since fetch may change its word while the block is busy.
  always_comb begin
    state_d    = state_q;
    greater_d  = greater_q;
    two_word_d = two_word_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d    = ST_READ;
          greater_d  = is_greater;
          two_word_d = fetch_in.next_two_word;
        end
      end
      ST_READ: begin
        if (take) begin
          state_d = ST_NOP1;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_NOP1: begin
        // Second word of a skipped two-word instruction costs one more.
        if (two_word_q) begin
          state_d = ST_NOP2;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_NOP2: begin
        state_d = ST_IDLE;
      end
      default: begin
        // An illegal code falls back to idle rather than hanging fetch.
        state_d = ST_IDLE;
      end
    endcase
  end

  // Register the sequence state.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q    <= ST_IDLE;
      greater_q  <= 1'b0;
      two_word_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      greater_q  <= greater_d;
      two_word_q <= two_word_d;
    end
  end

  // Next data request. The address is captured when a word is taken and
  // held until the next instruction; the read strobe lasts one cycle.
  always_comb begin
    daddr_d = daddr_q;
    dread_d = 1'b0;
    if (start) begin
      daddr_d = addr_calc;
      dread_d = 1'b1;
    end
  end

  // Register the data request.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      daddr_q <= '0;
      dread_q <= 1'b0;
    end else begin
      daddr_q <= daddr_d;
      dread_q <= dread_d;
    end
  end

  // Next results. Busy stalls fetch for every cycle after the first,
  // flush discards one fetched word per no-operation cycle, and the cycle
  // count stays until the next instruction leaves its read state.
  always_comb begin
    flush_d  = 1'b0;
    busy_d   = 1'b0;
    skip_d   = 1'b0;
    cycles_d = cycles_q;
    case (state_q)
      ST_IDLE: begin
        busy_d = start;
      end
      ST_READ: begin
        if (take) begin
          flush_d  = 1'b1;
          skip_d   = 1'b1;
          busy_d   = 1'b1;
          cycles_d = two_word_q ? CYC_SKIP_TWO_WORD : CYC_SKIP;
        end else begin
          cycles_d = CYC_NO_SKIP;
        end
      end
      ST_NOP1: begin
        // The second word of a two-word instruction is discarded as well.
        if (two_word_q) begin
          flush_d = 1'b1;
          busy_d  = 1'b1;
        end
      end
      ST_NOP2: begin
        busy_d = 1'b0;
      end
      default: begin
        busy_d = 1'b0;
      end
    endcase
  end

  // Register the results.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flush_q  <= 1'b0;
      busy_q   <= 1'b0;
      skip_q   <= 1'b0;
      cycles_q <= 2'h0;
    end else begin
      flush_q  <= flush_d;
      busy_q   <= busy_d;
      skip_q   <= skip_d;
      cycles_q <= cycles_d;
    end
  end

  // All outputs come straight from flip-flops.
  assign daddr_out  = daddr_q;
  assign dread_out  = dread_q;
  assign flush_out  = flush_q;
  assign busy_out   = busy_q;
  assign skip_out   = skip_q;
  assign cycles_out = cycles_q;

endmodule
`default_nettype wire

// file: cmp_skip_sva.sv
// Checker for the compare-skip block, bound to its top module.
// Assumes the clock and reset of compare_skip_execute.
`timescale 1ns/1ns
`default_nettype none
module cmp_skip_sva (
  input wire logic                    mclk_in,    // Clock.
  input wire logic                    reset_n_in, // Reset, low.
  input wire cmp_skip_pkg::fetch_type fetch_in,   // Fetched word.
  input wire logic [7:0]     working_register_in, // W value.
  input wire logic [7:0]              data_byte_in, // Read byte.
  input wire logic                    dread_out,  // Read strobe.
  input wire logic                    flush_out,  // Discard.
  input wire logic                    busy_out,   // Stall.
  input wire logic                    skip_out,   // Skip pulse.
  input wire logic [1:0]              cycles_out  // Cycle count.
);
  import cmp_skip_pkg::*;
  logic take_g, take_l, gt_q, tw_q;
  // Decode of a request taken while idle.
  assign take_g = !busy_out && fetch_in.valid &&
    fetch_in.word[15:9] == {OPC_HIGH, OPC_SUB_GREATER};
  assign take_l = !busy_out && fetch_in.valid &&
    fetch_in.word[15:9] == {OPC_HIGH, OPC_SUB_LESS};
  // Remembers the kind of the running instruction.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gt_q <= 1'b0;
      tw_q <= 1'b0;
    end else if (take_g || take_l) begin
      gt_q <= take_g;
      tw_q <= fetch_in.next_two_word;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  chk_take_greater: assert property (
    take_g |=> dread_out && busy_out) else $error("greater not taken");
  chk_take_less: assert property (
    take_l |=> dread_out && busy_out) else $error("less not taken");
  chk_ignore_other: assert property (
    !busy_out && !take_g && !take_l |=> !dread_out)
    else $error("read without request");
  chk_skip_greater: assert property (
    dread_out && gt_q && data_byte_in > working_register_in
    |=> skip_out && flush_out) else $error("greater skip missing");
  chk_skip_less: assert property (
    dread_out && !gt_q && data_byte_in < working_register_in
    |=> skip_out && flush_out) else $error("less skip missing");
  chk_equal_stay: assert property (
    dread_out && data_byte_in == working_register_in
    |=> !skip_out && cycles_out == CYC_NO_SKIP) else $error("equal skipped");
  chk_two_word: assert property (
    skip_out && tw_q |-> cycles_out == CYC_SKIP_TWO_WORD ##1 flush_out)
    else $error("two-word skip wrong");
  chk_one_word: assert property (
    skip_out && !tw_q |-> cycles_out == CYC_SKIP ##1 !flush_out && !busy_out)
    else $error("one-word skip wrong");
endmodule
`default_nettype wire

// file: data_mem_model.sv
// Data memory model answering the block's reads with a fixed pattern.
// Assumes the address is held through the read cycle.
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
  input  wire cmp_skip_pkg::daddr_type daddr_in,      // Address.
  input  wire logic                    dread_in,      // Read strobe.
  output var  logic [7:0]              data_byte_out  // Byte.
);
  import cmp_skip_pkg::*;
  logic [7:0] b;
  // Outside a read the byte is inverted so stale data never matches.
  always_comb begin
    b = daddr_in.addr[7:0] ^ {daddr_in.addr[11:8], daddr_in.addr[3:0]};
    data_byte_out = dread_in ? b : ~b;
  end
endmodule
`default_nettype wire

// file: test_compare_skip_execute.sv
// Self-checking bench for compare_skip_execute with a memory model.
// Assumes the package and both design files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_compare_skip_execute;
  import cmp_skip_pkg::*;
  logic mclk_in, reset_n_in, ext, dread, flush, busy, skip;
  logic [3:0] bank_select_register;
  logic [11:0] fsr;
  logic [7:0] working_register, dbyte;
  logic [1:0] cyc;
  fetch_type fetch;
  daddr_type daddr;
  logic [31:0] seed = 32'hB991;
  int error_cnt = 0;
  int tests_run = 0;
  compare_skip_execute i_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .fetch_in(fetch), .bank_select_register_in(bank_select_register), .extended_set_in(ext),
    .fsr_index_in(fsr), .working_register_in(working_register), .data_byte_in(dbyte),
    .daddr_out(daddr), .dread_out(dread), .flush_out(flush),
    .busy_out(busy), .skip_out(skip), .cycles_out(cyc));
  data_mem_model i_mem (.daddr_in(daddr), .dread_in(dread),
    .data_byte_out(dbyte));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected data address from access bit and register field.
  function automatic daddr_type ea_of(input logic a, input logic [7:0] f);
    if (a) return '{1'b0, {bank_select_register, f}};
    if (ext && f <= 8'h5F) return '{1'b1, fsr + {4'h0, f}};
    return '{1'b0, {(f < 8'h60) ? 4'h0 : 4'hF, f}};
  endfunction
  // One instruction from fetch to its last cycle.
  task automatic run(input logic [15:0] w, input logic tw,
                     input logic [1:0] rel, input logic [7:0] rnd);
    daddr_type ea;
    logic [7:0] b;
    logic hit, sk;
    ea = ea_of(w[8], w[7:0]);
    hit = w[15:12] == 4'h6 && w[11:9] inside {3'h2, 3'h0};
    b = ea.addr[7:0] ^ {ea.addr[11:8], ea.addr[3:0]};
    working_register = (rel == 2'h3) ? rnd : b + {6'h0, rel} - 8'h01;
    fetch = '{1'b1, w, tw};
    @(negedge mclk_in);
    check(dread, hit);
    check(busy, hit);
    if (hit) begin
      fetch.valid = 1'b0;
      check(daddr, ea);
      sk = w[10] ? b > working_register : b < working_register;
      @(negedge mclk_in);
      check({skip, flush}, {sk, sk});
      check(cyc, sk ? (tw ? 2'h3 : 2'h2) : 2'h1);
      check(busy, sk);
      if (sk) begin
        @(negedge mclk_in);
        check({flush, busy}, {tw, tw});
        if (tw) @(negedge mclk_in);
      end
    end
  endtask
  // Clock at 50 MHz.
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // Watchdog cuts a hang short.
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  // Reset, then corner fields first and random instructions after.
  initial begin
    logic [7:0] f;
    logic [15:0] w;
    reset_n_in = 1'b0;
    fetch = '0;
    {ext, bank_select_register, fsr, working_register} = '0;
    repeat (10) @(negedge mclk_in);
    reset_n_in = 1'b1;
    for (int i = 0; i < 300; i++) begin
      seed = xs(seed);
      {ext, bank_select_register, fsr} = seed[31:15];
      f = (i < 4) ? 8'h5F + 8'(i / 2) : seed[7:0];
      w = {4'h6, seed[14] ? 3'h2 : 3'h0, seed[8] && i > 3, f};
      if (i < 4) ext = 1'b1;
      if (seed[13:10] == 4'h0) w[11:9] = 3'h1;
      run(w, seed[9], seed[12:11], seed[22:15]);
    end
    wrap_up();
  end
endmodule
bind compare_skip_execute cmp_skip_sva i_sva (.mclk_in(mclk_in),
  .reset_n_in(reset_n_in), .fetch_in(fetch_in),
  .working_register_in(working_register_in), .data_byte_in(data_byte_in),
  .dread_out(dread_out), .flush_out(flush_out), .busy_out(busy_out),
  .skip_out(skip_out), .cycles_out(cycles_out));
`default_nettype wire
